// ===== logic/l1cram_bank.sv
// Purpose: One RAM bank of flip-flops, indexed by line
// Assumes: One access per cycle
// Notes: Read data registered
`timescale 1ns/1ps
module l1cram_bank
#(
   parameter int WIDTH = 39,
   parameter int LINES = 128
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic we,
   input wire logic [$clog2(LINES)-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);
   // ==========================================
   // Storage
   typedef struct packed
   {
      logic [LINES-1:0][WIDTH-1:0] mem;
      logic [WIDTH-1:0] rd;
   } l1cram_bst_t;
   l1cram_bst_t st_ff;
   l1cram_bst_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      if (en && we)
      begin
         nxt_st.mem[addr] = wdata;
      end
      if (en && !we)
      begin
         nxt_st.rd = st_ff.mem[addr];
      end
   end
   // Large flop array; real builds swap in a RAM macro here
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
   assign rdata = st_ff.rd;
endmodule // l1cram_bank

// ===== logic/l1cram_cfg.svh
// Purpose: Constants for the L1 cache RAM banking and exclusive monitor block
// Assumes: One core clock, active-low asynchronous reset
// Notes: Offsets, field positions, reset values and widths
// Function
// - Tag store has four banks; width 29..25 bits, lines 32..512 by cache size.
// - Data cache store is eight 32-bit banks, 128..2048 lines, four ways.
// - Instruction data store may be four 64-bit banks, same depths.
// - Nonsequential read enables every bank in one access.
// - Sequential read enables only the bank holding the data.
// - Whole line read to eviction buffer in one cycle, 256 bits.
// - Whole line written from linefill buffer in one cycle, 256 bits.
// - 64-bit reads select two words of one way from one address.
// - With ECC, instruction banks carry 8 check bits per 64 data bits.
// - With ECC, data banks carry 7 check bits per word, 39-bit entries.
// - ECC data entry holds data in [31:0], check code above it.
// - Control register bit 2 enables data cache, bit 12 instruction cache.
// - Local monitor is two-state, open and exclusive, for all access sizes.
// - Every load-exclusive moves the monitor to exclusive.
// - External events return the monitor to open; a load-exclusive in the same cycle leaves it exclusive.
// - Monitor keeps state for its own core only, records no address.
// - Store-exclusive in open state fails and does not update memory.
// - Tag bit 22 is the whole-line valid flag.
// - With ECC, every tag entry widens by seven check bits.
`ifndef L1CRAM_CFG_SVH
`define L1CRAM_CFG_SVH
`define L1C_CTRL_DCACHE_BIT 2
`define L1C_CTRL_ICACHE_BIT 12
`define L1C_AUX_ECC_LO 9
`define L1C_AUX_ECC_HI 10
`define L1C_TAG_VALID_BIT 22
`define L1C_TAG_ECC_BITS 7
`define L1C_TAG_W_4KB 29
`define L1C_TAG_LINES_4KB 32
`define L1C_DATA_LINES_4KB 128
`define L1C_DBANKS 8
`define L1C_IBANKS 4
`define L1C_WORD_W 32
`define L1C_DECC_BITS 7
`define L1C_IECC_PER64 8
`define L1C_LINE_W 256
`define L1C_WAYS 4
`define L1C_REG_CTRL 32'h0000_0000
`define L1C_REG_AUX 32'h0000_0004
`define L1C_REG_STAT 32'h0000_0008
`define L1C_CTRL_RST 32'h0000_0000
`define L1C_AUX_RST 32'h0000_0000
`endif

// ===== logic/l1cram_excl_mon.sv
// Purpose: Local exclusive monitor, two states
// Assumes: One request per cycle from the load/store unit
// Notes: No address is held
`timescale 1ns/1ps
module l1cram_excl_mon
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire l1cram_pkg::l1cram_excl_req_t req,
   input wire logic ext_clear,
   output l1cram_pkg::l1cram_excl_rsp_t rsp,
   output l1cram_pkg::l1cram_mon_t mon_state
);
   import l1cram_pkg::*;
   // ==========================================
   // State
   typedef struct packed
   {
      l1cram_mon_t mon;
      l1cram_excl_rsp_t rsp;
   } l1cram_mst_t;
   l1cram_mst_t st_ff;
   l1cram_mst_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rsp = '0;
      // Own core only, so one state bit and no address tag
      if (ext_clear)
      begin
         nxt_st.mon = L1C_MON_OPEN;
      end
      if (req.valid)
      begin
         unique case (req.op)
            L1C_EX_LOAD:
            begin
               // Load wins over a same-cycle external clear
               nxt_st.mon = L1C_MON_EXCL;
            end
            L1C_EX_STORE:
            begin
               nxt_st.rsp.done = 1'b1;
               nxt_st.rsp.success = (st_ff.mon == L1C_MON_EXCL) && !ext_clear;
               nxt_st.rsp.mem_write_en = (st_ff.mon == L1C_MON_EXCL) && !ext_clear;
               nxt_st.mon = L1C_MON_OPEN;
            end
            L1C_EX_CLEAR:
            begin
               nxt_st.mon = L1C_MON_OPEN;
            end
            default:
            begin
               nxt_st.mon = st_ff.mon;
            end
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '{mon: L1C_MON_OPEN, rsp: '0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
   assign rsp = st_ff.rsp;
   assign mon_state = st_ff.mon;
endmodule // l1cram_excl_mon

// ===== logic/l1cram_pkg.sv
// Purpose: Types for the L1 cache RAM block
// Assumes: Included constants header
// Notes: Types only
package l1cram_pkg;
   typedef enum logic [0:0] {L1C_MON_OPEN = 1'b0, L1C_MON_EXCL = 1'b1} l1cram_mon_t;
   typedef enum logic [2:0]
   {
      L1C_OP_NONE = 3'h0,
      L1C_OP_NSEQ = 3'h1,
      L1C_OP_SEQ = 3'h2,
      L1C_OP_EVICT = 3'h3,
      L1C_OP_FILL = 3'h4,
      L1C_OP_WRITE = 3'h5
   } l1cram_op_t;
   typedef enum logic [1:0]
   {
      L1C_EX_LOAD = 2'h0,
      L1C_EX_STORE = 2'h1,
      L1C_EX_CLEAR = 2'h2
   } l1cram_exop_t;
   typedef enum logic [1:0]
   {
      L1C_SZ_BYTE = 2'h0,
      L1C_SZ_HALF = 2'h1,
      L1C_SZ_WORD = 2'h2,
      L1C_SZ_DOUBLE = 2'h3
   } l1cram_size_t;
   typedef struct packed
   {
      logic valid;
      l1cram_exop_t op;
      l1cram_size_t size;
   } l1cram_excl_req_t;
   typedef struct packed
   {
      logic done;
      logic success;
      logic mem_write_en;
   } l1cram_excl_rsp_t;
   typedef struct packed
   {
      logic valid;
      l1cram_op_t op;
      logic [1:0] way;
      logic [10:0] index;
      logic [2:0] word;
      logic [31:0] wdata;
   } l1cram_req_t;
endpackage

// ===== logic/l1cram_top.sv
// Purpose: L1 data RAM banking, tag store, AXI4-Lite control, exclusive monitor
// Assumes: Inputs synchronous to core_clk; one RAM op per cycle
// Notes: Cache size picked by LINES parameters
`timescale 1ns/1ps
`include "l1cram_cfg.svh"
module l1cram_top
#(
   parameter int DATA_LINES = `L1C_DATA_LINES_4KB,
   parameter int TAG_LINES = `L1C_TAG_LINES_4KB,
   parameter int TAG_W = `L1C_TAG_W_4KB,
   parameter bit ECC_EN = 1'b1,
   parameter bit IBANK64 = 1'b0
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire l1cram_pkg::l1cram_req_t ram_req,
   input wire logic [`L1C_LINE_W-1:0] fill_line,
   input wire logic [`L1C_DBANKS*`L1C_DECC_BITS-1:0] fill_ecc,
   output logic [`L1C_LINE_W-1:0] evict_line,
   output logic evict_valid,
   output logic [63:0] rd_dword,
   output logic rd_valid,
   output logic [`L1C_DBANKS-1:0] bank_en,
   input wire logic tag_we,
   input wire logic [$clog2(TAG_LINES)-1:0] tag_index,
   input wire logic [1:0] tag_way,
   input wire logic [TAG_W+`L1C_TAG_ECC_BITS-1:0] tag_wdata,
   output logic [`L1C_WAYS-1:0] tag_line_valid,
   input wire l1cram_pkg::l1cram_excl_req_t excl_req,
   input wire logic excl_ext_clear,
   output l1cram_pkg::l1cram_excl_rsp_t excl_rsp,
   output logic dcache_en,
   output logic icache_en,
   output logic [1:0] ecc_ctrl,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import l1cram_pkg::*;
   // ==========================================
   // Widths
   localparam int DW = ECC_EN ? `L1C_WORD_W + `L1C_DECC_BITS : `L1C_WORD_W;
   localparam int IW = ECC_EN ? 64 + `L1C_IECC_PER64 : 64;
   localparam int TW = ECC_EN ? TAG_W + `L1C_TAG_ECC_BITS : TAG_W;
   localparam int AW = $clog2(DATA_LINES);
   localparam int TAW = $clog2(TAG_LINES);
   localparam int NB = IBANK64 ? `L1C_IBANKS : `L1C_DBANKS;
   localparam int BW = IBANK64 ? IW : DW;
   localparam int BPW = IBANK64 ? 2 : 1;
   // ==========================================
   // State
   typedef struct packed
   {
      logic [31:0] ctrl;
      logic [31:0] aux;
      logic aw_held;
      logic [31:0] awaddr;
      logic w_held;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      l1cram_op_t op_q;
      logic [2:0] word_q;
   } l1cram_tst_t;
   l1cram_tst_t st_ff;
   l1cram_tst_t nxt_st;
   logic [NB-1:0] en_c;
   logic we_c;
   logic [NB-1:0][BW-1:0] bank_wd;
   logic [NB-1:0][BW-1:0] bank_rd;
   logic [`L1C_DBANKS-1:0][31:0] rd_words;
   logic [`L1C_WAYS-1:0][TW-1:0] tag_rd;
   l1cram_mon_t mon_state;
   logic [AW-1:0] ram_addr;
   logic [31:0] wr_addr;
   logic aw_ok;
   logic w_ok;
   // ==========================================
   // Bank enables
   // Address covers way and line; two words of one way share it
   assign ram_addr = AW'({ram_req.index[AW-3:0], ram_req.way});
   always_comb
   begin
      en_c = '0;
      we_c = 1'b0;
      if (ram_req.valid)
      begin
         unique case (ram_req.op)
            L1C_OP_NONE:
            begin
               en_c = '0;
            end
            L1C_OP_NSEQ:
            begin
               en_c = '1;
            end
            L1C_OP_SEQ:
            begin
               en_c[ram_req.word / BPW] = 1'b1;
            end
            L1C_OP_EVICT:
            begin
               en_c = '1;
            end
            L1C_OP_FILL:
            begin
               en_c = '1;
               we_c = 1'b1;
            end
            L1C_OP_WRITE:
            begin
               en_c[ram_req.word / BPW] = 1'b1;
               we_c = 1'b1;
            end
            default:
            begin
               en_c = '0;
            end
         endcase
      end
   end
   // ==========================================
   // Banks
   genvar g;
   generate
      for (g = 0; g < NB; g++)
      begin : g_bank
         always_comb
         begin
            if (ram_req.op == L1C_OP_FILL)
            begin
               bank_wd[g] = BW'({fill_ecc[g*`L1C_DECC_BITS +: `L1C_DECC_BITS],
                  fill_line[g*32*BPW +: 32*BPW]});
            end
            else
            begin
               bank_wd[g] = BW'(ram_req.wdata);
            end
         end
         l1cram_bank #(.WIDTH(BW), .LINES(DATA_LINES)) u_bank
         (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .en(en_c[g]),
            .we(we_c),
            .addr(ram_addr),
            .wdata(bank_wd[g]),
            .rdata(bank_rd[g])
         );
         if (IBANK64)
         begin : g_w64
            assign rd_words[2*g] = bank_rd[g][31:0];
            assign rd_words[2*g+1] = bank_rd[g][63:32];
         end
         else
         begin : g_w32
            assign rd_words[g] = bank_rd[g][31:0];
         end
      end
      for (g = 0; g < `L1C_WAYS; g++)
      begin : g_tag
         l1cram_bank #(.WIDTH(TW), .LINES(TAG_LINES)) u_tag
         (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .en(1'b1),
            .we(tag_we && (tag_way == 2'(g))),
            .addr(tag_index),
            .wdata(tag_wdata[TW-1:0]),
            .rdata(tag_rd[g])
         );
         assign tag_line_valid[g] = tag_rd[g][`L1C_TAG_VALID_BIT];
      end
   endgenerate
   assign evict_line = rd_words;
   assign evict_valid = (st_ff.op_q == L1C_OP_EVICT);
   assign rd_dword = {rd_words[{st_ff.word_q[2:1], 1'b1}], rd_words[{st_ff.word_q[2:1], 1'b0}]};
   assign rd_valid = (st_ff.op_q == L1C_OP_NSEQ) || (st_ff.op_q == L1C_OP_SEQ);
   assign bank_en = `L1C_DBANKS'(en_c);
   // ==========================================
   // Exclusive monitor
   l1cram_excl_mon u_mon
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req(excl_req),
      .ext_clear(excl_ext_clear),
      .rsp(excl_rsp),
      .mon_state(mon_state)
   );
   // ==========================================
   // AXI4-Lite slave
   assign aw_ok = st_ff.aw_held || s_axi_awvalid;
   assign w_ok = st_ff.w_held || s_axi_wvalid;
   assign wr_addr = st_ff.aw_held ? st_ff.awaddr : s_axi_awaddr;
   assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
   assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
   assign s_axi_arready = !st_ff.rvalid;
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.op_q = ram_req.valid ? ram_req.op : L1C_OP_NONE;
      nxt_st.word_q = ram_req.word;
      if (s_axi_awvalid && s_axi_awready)
      begin
         nxt_st.aw_held = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         nxt_st.w_held = 1'b1;
         nxt_st.wdata = s_axi_wdata;
         nxt_st.wstrb = s_axi_wstrb;
      end
      if (aw_ok && w_ok && !st_ff.bvalid)
      begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = 2'h0;
         for (int b = 0; b < 4; b++)
         begin
            if ((st_ff.w_held ? st_ff.wstrb[b] : s_axi_wstrb[b]))
            begin
               if (wr_addr == `L1C_REG_CTRL)
               begin
                  nxt_st.ctrl[b*8 +: 8] = st_ff.w_held ? st_ff.wdata[b*8 +: 8]
                     : s_axi_wdata[b*8 +: 8];
               end
               else if (wr_addr == `L1C_REG_AUX)
               begin
                  nxt_st.aux[b*8 +: 8] = st_ff.w_held ? st_ff.wdata[b*8 +: 8]
                     : s_axi_wdata[b*8 +: 8];
               end
            end
         end
         // Full word decode, so nothing aliases above the map
         if (wr_addr != `L1C_REG_CTRL && wr_addr != `L1C_REG_AUX)
         begin
            nxt_st.bresp = 2'h2;
         end
      end
      if (st_ff.bvalid && s_axi_bready)
      begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.rvalid && s_axi_rready)
      begin
         nxt_st.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = 2'h0;
         nxt_st.rdata = 32'h0000_0000;
         if (s_axi_araddr == `L1C_REG_CTRL)
         begin
            nxt_st.rdata = st_ff.ctrl;
         end
         else if (s_axi_araddr == `L1C_REG_AUX)
         begin
            nxt_st.rdata = st_ff.aux;
         end
         else if (s_axi_araddr == `L1C_REG_STAT)
         begin
            nxt_st.rdata = {31'h0, mon_state};
         end
         else
         begin
            nxt_st.rresp = 2'h2;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
         st_ff.ctrl <= `L1C_CTRL_RST;
         st_ff.aux <= `L1C_AUX_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
   assign s_axi_bvalid = st_ff.bvalid;
   assign s_axi_bresp = st_ff.bresp;
   assign s_axi_rvalid = st_ff.rvalid;
   assign s_axi_rdata = st_ff.rdata;
   assign s_axi_rresp = st_ff.rresp;
   // Enables only gate users; invalidation order is software's job
   assign dcache_en = st_ff.ctrl[`L1C_CTRL_DCACHE_BIT];
   assign icache_en = st_ff.ctrl[`L1C_CTRL_ICACHE_BIT];
   assign ecc_ctrl = st_ff.aux[`L1C_AUX_ECC_HI:`L1C_AUX_ECC_LO];
endmodule // l1cram_top

// ===== tb/l1cram_l2_model.sv
// Purpose: Level-two side model that supplies whole lines for linefill
// Assumes: Line picked by set and way of the current request
// Notes: Pattern is unique per set, way and word
`timescale 1ns/1ps
module l1cram_l2_model
(
   input wire logic [4:0] set_idx,
   input wire logic [1:0] way,
   output logic [255:0] line,
   output logic [55:0] ecc
);
   // ==========================================
   // Line pattern, one whole line per request
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         line[i*32 +: 32] = {8'ha5, set_idx, 3'(i), way, 14'h1c3};
         ecc[i*7 +: 7] = {way, set_idx ^ 5'(i)};
      end
   end
endmodule // l1cram_l2_model

// ===== tb/l1cram_top_checker.sv
// Purpose: Port assertions for the cache RAM and exclusive monitor
// Assumes: Bound to l1cram_top, one clock domain
// Notes: Sees ports only
`timescale 1ns/1ps
`include "l1cram_cfg.svh"
module l1cram_top_checker
#(
   parameter int TAG_LINES = 32,
   parameter int TAG_W = 29
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire l1cram_pkg::l1cram_req_t ram_req,
   input wire logic evict_valid,
   input wire logic rd_valid,
   input wire logic [7:0] bank_en,
   input wire logic tag_we,
   input wire logic [$clog2(TAG_LINES)-1:0] tag_index,
   input wire logic [1:0] tag_way,
   input wire logic [TAG_W+`L1C_TAG_ECC_BITS-1:0] tag_wdata,
   input wire logic [3:0] tag_line_valid,
   input wire l1cram_pkg::l1cram_excl_req_t excl_req,
   input wire logic excl_ext_clear,
   input wire l1cram_pkg::l1cram_excl_rsp_t excl_rsp
);
   import l1cram_pkg::*;
   logic ld;
   logic st;
   logic rv;
   assign ld = excl_req.valid && excl_req.op == L1C_EX_LOAD;
   assign st = excl_req.valid && excl_req.op == L1C_EX_STORE;
   assign rv = ram_req.valid;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // RAM banking
   a_nseq_all_banks: assert property (rv && ram_req.op == L1C_OP_NSEQ |-> bank_en == 8'hff)
      else $error("nonsequential read left a bank off");
   a_seq_one_bank: assert property (rv && ram_req.op == L1C_OP_SEQ
      |-> bank_en == (8'h01 << ram_req.word))
      else $error("sequential read enabled wrong banks");
   a_evict_next: assert property (rv && ram_req.op == L1C_OP_EVICT |=> evict_valid)
      else $error("evict line not ready next cycle");
   a_read_next: assert property (rv && ram_req.op inside {L1C_OP_NSEQ, L1C_OP_SEQ}
      |=> rd_valid)
      else $error("read data not ready next cycle");
   a_tag_valid_bit: assert property (tag_we ##1 (!tag_we && $stable(tag_index))
      |=> tag_line_valid[$past(tag_way, 2)] == $past(tag_wdata[`L1C_TAG_VALID_BIT], 2))
      else $error("line valid does not follow tag bit");
   // ==========================================
   // Exclusive monitor
   a_store_after_load: assert property (ld ##1 (st && !excl_ext_clear)
      |=> excl_rsp.done && excl_rsp.success && excl_rsp.mem_write_en)
      else $error("store after load did not succeed");
   a_store_twice: assert property (st ##1 st |=> excl_rsp.done && !excl_rsp.success)
      else $error("second store succeeded");
   a_ext_clear_fail: assert property (st && excl_ext_clear
      |=> excl_rsp.done && !excl_rsp.success)
      else $error("store beside external clear succeeded");
   a_fail_no_write: assert property (excl_rsp.done && !excl_rsp.success
      |-> !excl_rsp.mem_write_en)
      else $error("failed store wrote memory");
   a_done_cause: assert property (excl_rsp.done |-> $past(st))
      else $error("store result without a store");
endmodule // l1cram_top_checker
bind l1cram_top l1cram_top_checker #(.TAG_LINES(TAG_LINES), .TAG_W(TAG_W)) u_chk
(
   .core_clk, .rst_n, .ram_req, .evict_valid, .rd_valid, .bank_en, .tag_we, .tag_index,
   .tag_way, .tag_wdata, .tag_line_valid, .excl_req, .excl_ext_clear, .excl_rsp
);

// ===== tb/test_l1_cache_ram_and_excl_monitor.sv
// Purpose: Self-checking bench for the cache RAM and exclusive monitor
// Assumes: Default 4KB build with check bits
// Notes: RAM traffic uses way 1, set 5
`timescale 1ns/1ps
module test_l1_cache_ram_and_excl_monitor;
   import l1cram_pkg::*;
   logic core_clk = 1'b0, rst_n = 1'b0, tag_we = 1'b0, excl_ext_clear = 1'b0;
   l1cram_req_t ram_req = '0;
   l1cram_excl_req_t excl_req = '0;
   l1cram_excl_rsp_t excl_rsp;
   logic [255:0] fill_line, evict_line, exp_line;
   logic [55:0] fill_ecc;
   logic [63:0] rd_dword;
   logic [7:0] bank_en;
   logic [4:0] tag_index = 5'h03;
   logic [1:0] tag_way = 2'h0, ecc_ctrl, s_axi_bresp, s_axi_rresp;
   logic [35:0] tag_wdata = 36'h0;
   logic [3:0] tag_line_valid, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic evict_valid, rd_valid, dcache_en, icache_en;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int fail_count = 0, checks_done = 0;
   always #20 core_clk = ~core_clk;
   l1cram_top dut
   (
      .core_clk, .rst_n, .ram_req, .fill_line, .fill_ecc, .evict_line, .evict_valid,
      .rd_dword, .rd_valid, .bank_en, .tag_we, .tag_index, .tag_way, .tag_wdata,
      .tag_line_valid, .excl_req, .excl_ext_clear, .excl_rsp, .dcache_en, .icache_en,
      .ecc_ctrl, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready
   );
   l1cram_l2_model l2 (.set_idx(ram_req.index[4:0]), .way(ram_req.way),
      .line(fill_line), .ecc(fill_ecc));
   l1cram_l2_model l2_ref (.set_idx(5'h05), .way(2'h1), .line(exp_line), .ecc());
   // ==========================================
   // Tasks
   task automatic finish_test;
      $display("Checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [255:0] exp, input logic [255:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", 256'h0, 256'(s_axi_bresp));
   endtask
   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] d,
      input logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(nm, 256'({r, d}), 256'({s_axi_rresp, s_axi_rdata}));
   endtask
   task automatic ram(input l1cram_op_t op, input logic [2:0] wd, input logic [31:0] d);
      @(posedge core_clk);
      ram_req <= '{valid: op != L1C_OP_NONE, op: op, way: 2'h1, index: 11'h005,
         word: wd, wdata: d};
   endtask
   task automatic tag_wr(input logic [1:0] w, input logic [35:0] d);
      @(posedge core_clk);
      tag_we <= 1'b1;
      tag_way <= w;
      tag_wdata <= d;
   endtask
   task automatic tag_chk(input logic [3:0] exp);
      @(posedge core_clk);
      tag_we <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk("tag_line_valid", 256'(exp), 256'(tag_line_valid));
   endtask
   task automatic ex(input logic v, input l1cram_exop_t op, input l1cram_size_t sz, input logic xc);
      @(posedge core_clk);
      excl_req <= '{valid: v, op: op, size: sz};
      excl_ext_clear <= xc;
   endtask
   task automatic st(input l1cram_size_t sz, input logic xc, input logic ok);
      ex(1'b1, L1C_EX_STORE, sz, xc);
      ex(1'b0, L1C_EX_CLEAR, sz, 1'b0);
      @(negedge core_clk);
      chk("excl_rsp", 256'({1'b1, ok, ok}), 256'(excl_rsp));
   endtask
   // ==========================================
   // Watchdog, far beyond the hundred or so cycles used
   initial
   begin
      #80000;
      fail_count++;
      finish_test;
   end
   // ==========================================
   // Tests
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      chk("ctl_out", 256'h0, 256'({dcache_en, icache_en, ecc_ctrl}));
      rdchk("ctrl_rst", 32'h0, 32'h0, 2'h0);
      rdchk("aux_rst", 32'h4, 32'h0, 2'h0);
      rdchk("stat_rst", 32'h8, 32'h0, 2'h0);
      rdchk("unmapped", 32'h10, 32'h0, 2'h2);
      // Check control changes only with caches off, then both invalidated
      axi_wr(32'h4, 32'h600);
      @(negedge core_clk);
      chk("ecc_ctrl", 256'h3, 256'(ecc_ctrl));
      rdchk("aux", 32'h4, 32'h600, 2'h0);
      for (int w = 0; w < 4; w++)
         tag_wr(2'(w), 36'h0);
      tag_chk(4'h0);
      tag_wr(2'h2, 36'h8_0040_0000);
      tag_chk(4'h4);
      tag_wr(2'h0, 36'hf_ffbf_ffff);
      tag_chk(4'h4);
      axi_wr(32'h0, 32'h1004);
      // Readback orders later fetches, as the barrier would
      rdchk("ctrl", 32'h0, 32'h1004, 2'h0);
      chk("enables", 256'h3, 256'({dcache_en, icache_en}));
      axi_wr(32'h0, 32'h1000);
      @(negedge core_clk);
      chk("enables_off", 256'h1, 256'({dcache_en, icache_en}));
      ram(L1C_OP_FILL, 3'h0, 32'h0);
      ram(L1C_OP_WRITE, 3'h3, 32'hdead_beef);
      ram(L1C_OP_NSEQ, 3'h3, 32'h0);
      @(negedge core_clk);
      chk("nseq_banks", 256'hff, 256'(bank_en));
      ram(L1C_OP_SEQ, 3'h5, 32'h0);
      @(negedge core_clk);
      chk("rd_dword", 256'({32'hdead_beef, exp_line[95:64]}), 256'(rd_dword));
      chk("seq_banks", 256'h20, 256'(bank_en));
      chk("rd_valid", 256'h1, 256'(rd_valid));
      ram(L1C_OP_EVICT, 3'h0, 32'h0);
      ram(L1C_OP_NONE, 3'h0, 32'h0);
      @(negedge core_clk);
      chk("evict_valid", 256'h1, 256'(evict_valid));
      chk("evict_line", {exp_line[255:128], 32'hdead_beef, exp_line[95:0]}, evict_line);
      // Lines may be stale after the cache was off: invalidate, then enable
      for (int w = 0; w < 4; w++)
         tag_wr(2'(w), 36'h0);
      tag_chk(4'h0);
      axi_wr(32'h0, 32'h1004);
      chk("enables_on", 256'h3, 256'({dcache_en, icache_en}));
      st(L1C_SZ_WORD, 1'b0, 1'b0);
      for (int s = 0; s < 4; s++)
      begin
         ex(1'b1, L1C_EX_LOAD, l1cram_size_t'(s), 1'b0);
         st(l1cram_size_t'(s), 1'b0, 1'b1);
      end
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_WORD, 1'b0);
      ex(1'b0, L1C_EX_CLEAR, L1C_SZ_WORD, 1'b0);
      rdchk("stat_excl", 32'h8, 32'h1, 2'h0);
      st(L1C_SZ_WORD, 1'b0, 1'b1);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_WORD, 1'b0);
      ex(1'b1, L1C_EX_STORE, L1C_SZ_WORD, 1'b0);
      st(L1C_SZ_WORD, 1'b0, 1'b0);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_HALF, 1'b0);
      ex(1'b1, L1C_EX_CLEAR, L1C_SZ_HALF, 1'b0);
      st(L1C_SZ_HALF, 1'b0, 1'b0);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_BYTE, 1'b0);
      ex(1'b0, L1C_EX_CLEAR, L1C_SZ_BYTE, 1'b1);
      st(L1C_SZ_BYTE, 1'b0, 1'b0);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_DOUBLE, 1'b1);
      st(L1C_SZ_DOUBLE, 1'b0, 1'b1);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_WORD, 1'b0);
      st(L1C_SZ_WORD, 1'b1, 1'b0);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_WORD, 1'b0);
      ex(1'b1, L1C_EX_LOAD, L1C_SZ_BYTE, 1'b0);
      st(L1C_SZ_WORD, 1'b0, 1'b1);
      finish_test;
   end
endmodule // test_l1_cache_ram_and_excl_monitor
